/* File: logic/serial_defs.svh */
// Purpose: Named constants for the asynchronous serial transceiver
// Assumes: Included by the package and the design file
// Notes:   Field positions refer to the received word layout
`ifndef SERIAL_DEFS_SVH
`define SERIAL_DEFS_SVH

`define FIFO_DEPTH        5'h10
`define FIFO_SINGLE       5'h01
`define PTR_STEP          4'h1
`define CNT_STEP          5'h01
`define TICK_LAST         4'hF
`define TICK_HALF         4'h7
`define TICK_STEP         4'h1
`define TICKS_PER_BIT     16
`define FRAC_ONE          23'h0_0040
`define DIV_ZERO          22'h00_0000
`define BIT_STEP          3'h1
`define WORD_BASE_LAST    3'h4
`define LEVEL_RESET       3'h2
`define LEVEL_EIGHTH      5'h02
`define LEVEL_QUARTER     5'h04
`define LEVEL_HALF        5'h08
`define LEVEL_3QUARTER    5'h0C
`define LEVEL_7EIGHTH     5'h0E
`define ERR_OVERRUN       11
`define ERR_BREAK         10
`define ERR_PARITY        9
`define ERR_FRAMING       8
`define TIMEOUT_BITS      32
`define RESET_CONTROL     3'h6

`endif

/* File: logic/serial_pkg.sv */
// Purpose: Types shared by the asynchronous serial transceiver
// Assumes: serial_defs.svh supplies the constants
// Notes:   Line format bit order follows the line format register layout
`include "serial_defs.svh"

package serial_pkg;

	typedef struct packed {
		logic       receiveEnable;
		logic       transmitEnable;
		logic       globalEnable;
	} control_t;

	typedef struct packed {
		logic       stickParity;
		logic [1:0] wordLength;
		logic       fifoEnable;
		logic       twoStop;
		logic       evenParity;
		logic       parityEnable;
		logic       sendBreak;
	} line_format_t;

	typedef struct packed {
		logic       busy;
		logic       txFull;
		logic       txEmpty;
		logic       rxFull;
		logic       rxEmpty;
		logic       txLevelHit;
		logic       rxLevelHit;
		logic       overrun;
		logic       rxTimeout;
	} status_t;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

	typedef struct packed {
		control_t          serialControl;
		logic [15:0]       divisorInteger;
		logic [5:0]        divisorFraction;
		logic [15:0]       wholeActive;
		logic [5:0]        fracActive;
		line_format_t      lineFormat;
		logic [2:0]        txLevel;
		logic [2:0]        rxLevel;
		logic [22:0]       accum;
		logic              tick;
		logic [15:0][7:0]  txMem;
		logic [3:0]        txWr;
		logic [3:0]        txRd;
		logic [4:0]        txCnt;
		tx_state_t         txState;
		logic [3:0]        txTick;
		logic [2:0]        txBit;
		logic [7:0]        txShift;
		logic              txParity;
		logic              serialOut;
		logic [15:0][11:0] rxMem;
		logic [3:0]        rxWr;
		logic [3:0]        rxRd;
		logic [4:0]        rxCnt;
		rx_state_t         rxState;
		logic [3:0]        rxTick;
		logic [2:0]        rxBit;
		logic [7:0]        rxShift;
		logic              rxParErr;
		logic              rxAllLow;
		logic              rxPrev;
		logic [9:0]        idleTicks;
		logic [11:0]       rxWord;
		status_t           status;
	} state_t;

endpackage

/* File: logic/async_serial_transceiver.sv */
// Purpose: Asynchronous serial transmitter and receiver with fractional rate generator and FIFOs
// Assumes: All inputs synchronous to clk; software disables the block before reconfiguring
// Notes:   Configuration and status are plain ports; write strobes are one-cycle pulses
`include "serial_defs.svh"

// Overview of operation
// [RULE1] Transmit and receive enable bits come out of reset set
// [RULE2] Disabling mid-character lets the current character finish first
// [RULE3] Software clears global enable before changing any setting
// [RULE4] Frame is start bit, data LSB first, optional parity, stop bits
// [RULE5] Receiver checks overrun, parity, framing, break and stores flags with data
// [RULE6] Divisor is 16-bit integer plus 6-bit fraction setting the bit period
// [RULE7] Tick at sixteen times baud; sixteen ticks per transmit bit; ticks time sampling
// [RULE8] Divisor and line format take effect together on a line format write
// [RULE9] Software writes divisor parts in any order then line format
// [RULE10] Software rounds fraction as fraction times 64 plus 0.5, truncated
// [RULE11] Both FIFOs hold 16 characters; receive entries carry four status bits
// [RULE12] Transmission starts once data is queued and runs back to back
// [RULE13] Busy while transmit data queued or a character is still leaving
// [RULE14] Falling edge starts receive; line rechecked on eighth tick, else false start
// [RULE15] Data bits sampled every sixteenth tick, then parity checked if enabled
// [RULE16] Stop bit must be high else framing error; character then pushed
// [RULE17] Five to eight data bits, even odd stick or no parity, one or two stops
// [RULE18] Break can be sent and a received break is detected
// [RULE19] FIFO depth selectable, including a single-character holding mode
// [RULE20] Trigger levels of one eighth up to seven eighths per FIFO
// [RULE21] Rate generator reaches 3.125 Mbps given a fast enough clock
// [RULE22] FIFOs start disabled as single holding registers until enabled
// [RULE23] Received word is eight data bits plus four error flags
// [RULE24] Receive timeout after 32 idle bit periods with data waiting
// [RULE25] Both trigger levels reset to the half-full point
// [RULE26] Break flagged when line stays low through a whole frame
// [RULE27] Character arriving at a full receive FIFO is dropped and overrun set
module async_serial_transceiver #(
	parameter int TIMEOUT_BITS = `TIMEOUT_BITS
) (
	// Clock and reset
	input  wire  logic                      clk,
	input  wire  logic                      rst_n,
	// Control register
	input  wire  logic                      controlWrite,
	input  wire  serial_pkg::control_t      controlIn,
	output       serial_pkg::control_t      controlOut,
	// Divisor and line format registers
	input  wire  logic                      divIntWrite,
	input  wire  logic [15:0]               divIntIn,
	input  wire  logic                      divFracWrite,
	input  wire  logic [5:0]                divFracIn,
	input  wire  logic                      lineWrite,
	input  wire  serial_pkg::line_format_t  lineIn,
	output       serial_pkg::line_format_t  lineOut,
	// Trigger level selects
	input  wire  logic                      levelWrite,
	input  wire  logic [2:0]                txLevelIn,
	input  wire  logic [2:0]                rxLevelIn,
	// Data port
	input  wire  logic                      txPush,
	input  wire  logic [7:0]                txByte,
	input  wire  logic                      rxPop,
	output       logic [11:0]               rxWord,
	// Status and clears
	input  wire  logic                      errorClear,
	input  wire  logic                      timeoutClear,
	output       serial_pkg::status_t       status,
	// Serial line
	input  wire  logic                      serial_in,
	output       logic                      serial_out
);
	import serial_pkg::*;

	localparam logic [9:0] TIMEOUT_TICKS = 10'(TIMEOUT_BITS * `TICKS_PER_BIT);

	state_t s_reg;
	state_t s_next;

	// Index of the last data bit for a given word length code
	function automatic logic [2:0] lastBit(input logic [1:0] len);
		lastBit = `WORD_BASE_LAST + {1'b0, len};
	endfunction

	// Parity bit for the active data bits
	function automatic logic parityOf(input logic [7:0] data, input line_format_t f);
		logic [7:0] mask;
		mask = 8'hFF >> (2'h3 - f.wordLength);
		if (f.stickParity) begin
			parityOf = ~f.evenParity;
		end else begin
			parityOf = ^(data & mask) ^ ~f.evenParity;
		end
	endfunction

	// Received bits enter at the top, so short words are shifted down
	function automatic logic [7:0] alignRx(input logic [7:0] data, input logic [1:0] len);
		alignRx = data >> (2'h3 - len);
	endfunction

	function automatic logic [4:0] levelMark(input logic [2:0] sel);
		unique case (sel)
			3'h0: levelMark = `LEVEL_EIGHTH;
			3'h1: levelMark = `LEVEL_QUARTER;
			3'h3: levelMark = `LEVEL_3QUARTER;
			3'h4: levelMark = `LEVEL_7EIGHTH;
			default: levelMark = `LEVEL_HALF;
		endcase
	endfunction

	logic [21:0] divisor;
	logic [22:0] accSum;
	logic [4:0]  depth;
	logic        txRun;
	logic        rxRun;
	logic        txTake;
	logic        txStore;
	logic        rxStore;
	logic        rxTake;
	logic        rxDone;
	logic [11:0] rxEntry;
	logic        rxBitEnd;
	logic        txBitEnd;
	logic [7:0]  rxAligned;

	always_comb begin
		s_next    = s_reg;
		divisor   = {s_reg.wholeActive, s_reg.fracActive};
		accSum    = s_reg.accum + `FRAC_ONE;
		depth     = s_reg.lineFormat.fifoEnable ? `FIFO_DEPTH : `FIFO_SINGLE; // [RULE19] [RULE22]
		txRun     = s_reg.serialControl.globalEnable & s_reg.serialControl.transmitEnable;
		rxRun     = s_reg.serialControl.globalEnable & s_reg.serialControl.receiveEnable;
		txTake    = 1'b0;
		rxDone    = 1'b0;
		rxEntry   = '0;
		txBitEnd  = s_reg.tick && (s_reg.txTick == `TICK_LAST);
		rxBitEnd  = s_reg.tick && (s_reg.rxTick == `TICK_LAST);
		rxAligned = alignRx(s_reg.rxShift, s_reg.lineFormat.wordLength);
		txStore   = txPush && (s_reg.txCnt < depth);
		rxTake    = rxPop && (s_reg.rxCnt != '0);

		// Register writes; the divisor only takes effect on a line format write
		if (controlWrite) begin
			s_next.serialControl = controlIn;
		end
		if (divIntWrite) begin
			s_next.divisorInteger = divIntIn; // [RULE6]
		end
		if (divFracWrite) begin
			s_next.divisorFraction = divFracIn; // [RULE6]
		end
		if (lineWrite) begin
			s_next.lineFormat  = lineIn; // [RULE8]
			s_next.wholeActive = s_next.divisorInteger; // [RULE8]
			s_next.fracActive  = s_next.divisorFraction; // [RULE8]
		end
		if (levelWrite) begin
			s_next.txLevel = txLevelIn; // [RULE20]
			s_next.rxLevel = rxLevelIn; // [RULE20]
		end

		// Fractional accumulator in 1/64 clock units; a divisor of one gives the top rate of one bit per 16 clocks
		s_next.tick = 1'b0;
		if (divisor == `DIV_ZERO) begin
			s_next.accum = '0;
		end else if (accSum >= {1'b0, divisor}) begin
			s_next.accum = accSum - {1'b0, divisor}; // [RULE7] [RULE21]
			s_next.tick  = 1'b1; // [RULE7]
		end else begin
			s_next.accum = accSum;
		end

		// Transmitter; enable is only looked at between characters
		if (s_reg.tick && s_reg.txState != TX_IDLE) begin
			s_next.txTick = s_reg.txTick + `TICK_STEP; // [RULE7]
		end
		unique case (s_reg.txState)
			TX_IDLE: begin
				if (txRun && s_reg.txCnt != '0) begin
					txTake          = 1'b1; // [RULE12]
					s_next.txShift  = s_reg.txMem[s_reg.txRd];
					s_next.txParity = parityOf(s_reg.txMem[s_reg.txRd], s_reg.lineFormat); // [RULE17]
					s_next.txState  = TX_START; // [RULE4]
					s_next.txTick   = '0;
				end
			end
			TX_START: begin
				if (txBitEnd) begin
					s_next.txState = TX_DATA; // [RULE2]
					s_next.txBit   = '0;
				end
			end
			TX_DATA: begin
				if (txBitEnd) begin
					s_next.txShift = s_reg.txShift >> 1; // [RULE4]
					s_next.txBit   = s_reg.txBit + `BIT_STEP;
					if (s_reg.txBit == lastBit(s_reg.lineFormat.wordLength)) begin
						s_next.txBit   = '0;
						s_next.txState = s_reg.lineFormat.parityEnable ? TX_PARITY : TX_STOP; // [RULE4] [RULE17]
					end
				end
			end
			TX_PARITY: begin
				if (txBitEnd) begin
					s_next.txState = TX_STOP;
				end
			end
			TX_STOP: begin
				if (txBitEnd) begin
					if (s_reg.lineFormat.twoStop && s_reg.txBit == '0) begin
						s_next.txBit = `BIT_STEP; // [RULE17]
					end else begin
						s_next.txState = TX_IDLE; // [RULE12]
					end
				end
			end
		endcase

		// Transmit FIFO; writes to a full FIFO are dropped
		if (txStore) begin
			s_next.txMem[s_reg.txWr] = txByte;
			s_next.txWr              = s_reg.txWr + `PTR_STEP;
		end
		if (txTake) begin
			s_next.txRd = s_reg.txRd + `PTR_STEP;
		end
		s_next.txCnt = s_reg.txCnt + (txStore ? `CNT_STEP : '0) - (txTake ? `CNT_STEP : '0); // [RULE11]

		unique case (s_next.txState)
			TX_START:  s_next.serialOut = 1'b0;
			TX_DATA:   s_next.serialOut = s_next.txShift[0];
			TX_PARITY: s_next.serialOut = s_next.txParity;
			default:   s_next.serialOut = 1'b1;
		endcase
		if (s_next.lineFormat.sendBreak) begin
			s_next.serialOut = 1'b0; // [RULE18]
		end

		// Receiver; needs a high line before a start edge, so a held break does not retrigger
		s_next.rxPrev = serial_in;
		if (s_reg.tick && s_reg.rxState != RX_IDLE) begin
			s_next.rxTick = s_reg.rxTick + `TICK_STEP; // [RULE7]
		end
		unique case (s_reg.rxState)
			RX_IDLE: begin
				if (rxRun && s_reg.rxPrev && !serial_in) begin
					s_next.rxState  = RX_START; // [RULE14]
					s_next.rxTick   = '0;
					s_next.rxAllLow = 1'b1;
				end
			end
			RX_START: begin
				if (s_reg.tick && s_reg.rxTick == `TICK_HALF) begin
					if (serial_in) begin
						s_next.rxState = RX_IDLE; // [RULE14]
					end else begin
						s_next.rxState = RX_DATA; // [RULE2]
						s_next.rxTick  = '0;
						s_next.rxBit   = '0;
					end
				end
			end
			RX_DATA: begin
				if (rxBitEnd) begin
					s_next.rxShift  = {serial_in, s_reg.rxShift[7:1]}; // [RULE15]
					s_next.rxAllLow = s_reg.rxAllLow & ~serial_in;
					s_next.rxBit    = s_reg.rxBit + `BIT_STEP;
					s_next.rxParErr = 1'b0;
					if (s_reg.rxBit == lastBit(s_reg.lineFormat.wordLength)) begin
						s_next.rxState = s_reg.lineFormat.parityEnable ? RX_PARITY : RX_STOP; // [RULE15]
					end
				end
			end
			RX_PARITY: begin
				if (rxBitEnd) begin
					s_next.rxParErr = serial_in != parityOf(rxAligned, s_reg.lineFormat); // [RULE15] [RULE17]
					s_next.rxAllLow = s_reg.rxAllLow & ~serial_in;
					s_next.rxState  = RX_STOP;
				end
			end
			RX_STOP: begin
				if (rxBitEnd) begin
					rxDone                = 1'b1; // [RULE16]
					rxEntry[7:0]          = rxAligned; // [RULE23]
					rxEntry[`ERR_FRAMING] = !serial_in; // [RULE16] [RULE5]
					rxEntry[`ERR_PARITY]  = s_reg.rxParErr; // [RULE5]
					rxEntry[`ERR_BREAK]   = s_reg.rxAllLow && !serial_in; // [RULE26] [RULE18]
					rxEntry[`ERR_OVERRUN] = s_reg.status.overrun; // [RULE5]
					s_next.rxState        = RX_IDLE;
				end
			end
		endcase

		// Receive FIFO; a character finding it full is lost and marks overrun
		rxStore = rxDone && (s_reg.rxCnt < depth);
		if (rxStore) begin
			s_next.rxMem[s_reg.rxWr] = rxEntry; // [RULE11] [RULE5]
			s_next.rxWr              = s_reg.rxWr + `PTR_STEP;
		end
		if (rxTake) begin
			s_next.rxRd = s_reg.rxRd + `PTR_STEP;
		end
		s_next.rxCnt = s_reg.rxCnt + (rxStore ? `CNT_STEP : '0) - (rxTake ? `CNT_STEP : '0); // [RULE11]
		if (rxDone && !rxStore) begin
			s_next.status.overrun = 1'b1; // [RULE27]
		end else if (errorClear) begin
			s_next.status.overrun = 1'b0;
		end

		// Idle timer restarts on any receive FIFO movement; it fires once per quiet spell
		if (rxStore || rxTake || s_next.rxCnt == '0) begin
			s_next.idleTicks = '0;
		end else if (s_reg.tick && s_reg.idleTicks != TIMEOUT_TICKS) begin
			s_next.idleTicks = s_reg.idleTicks + 10'h001;
		end
		if (s_reg.tick && s_next.idleTicks == TIMEOUT_TICKS && s_reg.idleTicks != TIMEOUT_TICKS) begin
			s_next.status.rxTimeout = 1'b1; // [RULE24]
		end else if (timeoutClear || s_next.rxCnt == '0) begin
			s_next.status.rxTimeout = 1'b0; // [RULE24]
		end

		// Registered views of FIFO head and flags
		s_next.rxWord         = s_next.rxMem[s_next.rxRd]; // [RULE23]
		s_next.status.busy    = (s_next.txCnt != '0) || (s_next.txState != TX_IDLE); // [RULE13]
		s_next.status.txEmpty = s_next.txCnt == '0;
		s_next.status.rxEmpty = s_next.rxCnt == '0;
		s_next.status.txFull  = s_next.txCnt >= (s_next.lineFormat.fifoEnable ? `FIFO_DEPTH : `FIFO_SINGLE);
		s_next.status.rxFull  = s_next.rxCnt >= (s_next.lineFormat.fifoEnable ? `FIFO_DEPTH : `FIFO_SINGLE);
		if (s_next.lineFormat.fifoEnable) begin
			s_next.status.txLevelHit = s_next.txCnt <= levelMark(s_next.txLevel); // [RULE20]
			s_next.status.rxLevelHit = s_next.rxCnt >= levelMark(s_next.rxLevel); // [RULE20]
		end else begin
			s_next.status.txLevelHit = s_next.txCnt == '0;
			s_next.status.rxLevelHit = s_next.rxCnt != '0;
		end

		// Synchronous reset overrides everything computed above
		if (!rst_n) begin
			s_next                = '0;
			s_next.serialControl  = `RESET_CONTROL; // [RULE1]
			s_next.txLevel        = `LEVEL_RESET; // [RULE25]
			s_next.rxLevel        = `LEVEL_RESET; // [RULE25]
			s_next.serialOut      = 1'b1;
			s_next.rxPrev         = 1'b1;
			s_next.status.txEmpty = 1'b1;
			s_next.status.rxEmpty = 1'b1;
			s_next.status.txLevelHit = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		s_reg <= s_next;
	end

	assign controlOut = s_reg.serialControl;
	assign lineOut    = s_reg.lineFormat;
	assign rxWord     = s_reg.rxWord;
	assign status     = s_reg.status;
	assign serial_out = s_reg.serialOut;

endmodule

/* File: testbench/async_serial_transceiver_asserts.sv */
// Purpose: Port-level checks for the asynchronous serial transceiver
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Sees only the top module ports; bound at the foot of this file
module async_serial_transceiver_asserts
	import serial_pkg::*;
#(
	parameter int TIMEOUT_BITS = 32
) (
	// Clock and reset
	input wire logic         clk,
	input wire logic         rst_n,
	// Settings
	input wire logic         controlWrite,
	input wire control_t     controlIn,
	input wire control_t     controlOut,
	input wire logic         lineWrite,
	input wire line_format_t lineIn,
	input wire line_format_t lineOut,
	// Data, status and line
	input wire logic         txPush,
	input wire logic         errorClear,
	input wire status_t      status,
	input wire logic         serial_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	reset_values_a: assert property ($rose(rst_n) |-> controlOut == 3'h6 && lineOut == 8'h00 && serial_out && status == 9'h058)
		else $error("values after reset differ");
	control_write_a: assert property (controlWrite |=> controlOut == $past(controlIn))
		else $error("control write not taken");
	line_write_a: assert property (lineWrite |=> lineOut == $past(lineIn))
		else $error("line format write not taken");
	busy_rise_a: assert property (txPush && !status.txFull |=> status.busy)
		else $error("busy did not rise after push");
	busy_hold_a: assert property (status.busy && !status.txEmpty |=> status.busy)
		else $error("busy dropped with data queued");
	idle_high_a: assert property (status.txEmpty && !status.busy && !lineOut.sendBreak && !$past(lineOut.sendBreak)
		|-> serial_out)
		else $error("line not idle high");
	tx_start_a: assert property ($fell(serial_out) && !lineOut.sendBreak |-> status.busy)
		else $error("start bit without busy");
	overrun_hold_a: assert property (status.overrun && !errorClear |=> status.overrun)
		else $error("overrun lost without clear");
	tx_single_a: assert property (!lineOut.fifoEnable && !status.txEmpty |-> status.txFull)
		else $error("single transmit holding not full");
	rx_single_a: assert property (!lineOut.fifoEnable && !status.rxEmpty |-> status.rxFull)
		else $error("single receive holding not full");

	cover property (status.overrun);
	cover property (status.rxTimeout);
	cover property ($fell(status.busy));
endmodule

bind async_serial_transceiver async_serial_transceiver_asserts #(.TIMEOUT_BITS(TIMEOUT_BITS)) checker_inst (
	.clk(clk), .rst_n(rst_n), .controlWrite(controlWrite), .controlIn(controlIn), .controlOut(controlOut),
	.lineWrite(lineWrite), .lineIn(lineIn), .lineOut(lineOut), .txPush(txPush), .errorClear(errorClear),
	.status(status), .serial_out(serial_out));

/* File: testbench/remote_serial_device.sv */
// Purpose: Remote asynchronous serial device facing the transceiver
// Assumes: Format and bit length in clocks are set by the bench
// Notes:   Line idles high; sent frames change at the falling clock edge
module remote_serial_device
	import serial_pkg::*;
(
	// Clock and settings
	input wire logic         clk,
	input wire line_format_t fmt,
	input wire logic [7:0]   bitClks,
	// Serial lines
	input wire logic         serial_out,
	output     logic         serial_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] heard[$];

	function automatic int frame_len();
		return 7 + fmt.wordLength + fmt.parityEnable + fmt.twoStop;
	endfunction

	// Start low, data LSB first, parity, stop bits high
	function automatic logic [11:0] frame_bits(input logic [7:0] data);
		logic [11:0] b;
		logic [7:0]  d;
		d = data & (8'hFF >> (2'h3 - fmt.wordLength));
		b = 12'hFFF;
		b[0] = 1'b0;
		for (int i = 0; i < 5 + fmt.wordLength; i++) b[i + 1] = d[i];
		if (fmt.parityEnable) b[6 + fmt.wordLength] = fmt.stickParity ? ~fmt.evenParity : (fmt.evenParity ? ^d : ~^d);
		return b;
	endfunction

	// Mid-bit sampling of each transmitted frame
	always begin
		logic [11:0] bits;
		@(negedge serial_out);
		bits = 12'hFFF;
		repeat (bitClks / 2) @(posedge clk);
		for (int i = 0; i < frame_len(); i++) begin
			bits[i] = serial_out;
			if (i < frame_len() - 1) repeat (bitClks) @(posedge clk);
		end
		heard.push_back(bits);
	end

	initial serial_in = 1'b1;

	// A held-low span stands for a false start or a break
	task automatic send(input logic [7:0] data, input logic [11:0] flip, input int lowClks);
		logic [11:0] b;
		b = frame_bits(data) ^ flip;
		if (lowClks > 0) begin
			@(negedge clk) serial_in = 1'b0;
			repeat (lowClks) @(negedge clk);
			serial_in = 1'b1;
		end else begin
			for (int i = 0; i < frame_len(); i++) begin
				@(negedge clk) serial_in = b[i];
				repeat (bitClks - 1) @(negedge clk);
			end
			@(negedge clk) serial_in = 1'b1;
		end
		repeat (2 * bitClks) @(negedge clk);
	endtask
endmodule

/* File: testbench/async_serial_transceiver_tb_top.sv */
// Purpose: Self-checking bench for the asynchronous serial transceiver
// Assumes: Divisor kept at one or two, so a bit lasts 16 or 32 clocks
// Notes:   Short receive timeout keeps the run brief
module async_serial_transceiver_tb_top;
	import serial_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic         clk = 1'b0, rst_n = 1'b0, serial_in, serial_out;
	logic         controlWrite = 1'b0, divIntWrite = 1'b0, divFracWrite = 1'b0, lineWrite = 1'b0;
	logic         txPush = 1'b0, rxPop = 1'b0, errorClear = 1'b0, timeoutClear = 1'b0, levelWrite = 1'b0;
	logic [2:0]   txLevelIn = 3'h2, rxLevelIn = 3'h2;
	control_t     controlIn = 3'h0, controlOut;
	line_format_t lineIn = 8'h00, lineOut;
	logic [15:0]  divIntIn = 16'h0000;
	logic [5:0]   divFracIn = 6'h00;
	logic [7:0]   txByte = 8'h00, bitClks = 8'h10, b;
	logic [11:0]  rxWord, flip;
	logic [7:0]   sent[$];
	status_t      status;
	int           n_errors = 0, checked = 0, seed = 51, div;

	always #12.5 clk = ~clk;

	async_serial_transceiver #(.TIMEOUT_BITS(2)) async_serial_transceiver_inst (
		.clk(clk), .rst_n(rst_n), .controlWrite(controlWrite), .controlIn(controlIn), .controlOut(controlOut),
		.divIntWrite(divIntWrite), .divIntIn(divIntIn), .divFracWrite(divFracWrite), .divFracIn(divFracIn),
		.lineWrite(lineWrite), .lineIn(lineIn), .lineOut(lineOut), .levelWrite(levelWrite), .txLevelIn(txLevelIn),
		.rxLevelIn(rxLevelIn), .txPush(txPush), .txByte(txByte), .rxPop(rxPop), .rxWord(rxWord),
		.errorClear(errorClear), .timeoutClear(timeoutClear), .status(status), .serial_in(serial_in),
		.serial_out(serial_out));

	remote_serial_device remote_serial_device_inst (.clk(clk), .fmt(lineIn), .bitClks(bitClks),
		.serial_out(serial_out), .serial_in(serial_in));

	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic pulse(ref logic s);
		@(negedge clk) s = 1'b1;
		@(negedge clk) s = 1'b0;
	endtask

	task automatic set_ctl(input control_t c);
		controlIn = c;
		pulse(controlWrite);
	endtask

	// Disable first, divisor then line format, enable last
	task automatic configure(input line_format_t f, input int d);
		set_ctl(3'h6);
		divIntIn = 16'(d);
		pulse(divIntWrite);
		divFracIn = 6'h00;
		pulse(divFracWrite);
		lineIn = f;
		pulse(lineWrite);
		bitClks = 8'(16 * d);
		set_ctl(3'h7);
	endtask

	task automatic push(input logic [7:0] v);
		txByte = v;
		sent.push_back(v);
		pulse(txPush);
	endtask

	task automatic wait_idle();
		for (int k = 0; k < 9000 && status.busy !== 1'b0; k++) @(negedge clk);
		repeat (2) @(negedge clk);
	endtask

	// Every queued byte must have left in order, framed by the format
	task automatic check_heard();
		check(12'(remote_serial_device_inst.heard.size()), 12'(sent.size()));
		while (remote_serial_device_inst.heard.size() > 0 && sent.size() > 0)
			check(remote_serial_device_inst.heard.pop_front(), remote_serial_device_inst.frame_bits(sent.pop_front()));
		remote_serial_device_inst.heard.delete();
		sent.delete();
	endtask

	function automatic logic [11:0] exp_word(input logic [7:0] v, input logic pe, input logic fe);
		return {2'b00, pe, fe, v & (8'hFF >> (2'h3 - lineIn.wordLength))};
	endfunction

	task automatic recv_check(input logic [11:0] exp, input logic [11:0] mask);
		for (int k = 0; k < 2000 && status.rxEmpty !== 1'b0; k++) @(negedge clk);
		check(rxWord & mask, exp);
		pulse(rxPop);
	endtask

	task automatic test_done(input string name);
		$display("Done %s: checks %0d, mismatches %0d", name, checked, n_errors);
	endtask

	initial begin
		line_format_t f;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		check({9'h000, controlOut}, 12'h006);
		check({3'h0, status}, 12'h058);
		test_done("reset");
		for (int i = 0; i < 8; i++) begin
			f = 8'h00;
			f.wordLength = i[1:0];
			f.evenParity = i[0];
			f.stickParity = i[1];
			f.parityEnable = (i != 0);
			f.twoStop = i[2];
			f.fifoEnable = 1'b1;
			div = 1 + i % 2;
			configure(f, div);
			push(8'($random(seed)));
			push(8'($random(seed)));
			wait_idle();
			check_heard();
			b = 8'($random(seed));
			flip = ({11'h000, i == 2} << (6 + f.wordLength)) | ({11'h000, i == 5} << (6 + f.wordLength + f.parityEnable));
			remote_serial_device_inst.send(b, flip, 0);
			recv_check(exp_word(b, i == 2, i == 5), 12'h3FF);
		end
		test_done("formats");
		remote_serial_device_inst.send(8'h00, 12'h000, 3);
		repeat (20 * bitClks) @(negedge clk);
		check({11'h000, status.rxEmpty}, 12'h001);
		remote_serial_device_inst.send(8'h00, 12'h000, 14 * bitClks);
		recv_check(12'h400, 12'h4FF);
		f.sendBreak = 1'b1;
		configure(f, div);
		repeat (14 * bitClks) @(negedge clk);
		check({11'h000, serial_out}, 12'h000);
		f.sendBreak = 1'b0;
		configure(f, div);
		repeat (2 * bitClks) @(negedge clk);
		remote_serial_device_inst.heard.delete();
		test_done("break");
		push(8'hA5);
		repeat (3 * bitClks) @(negedge clk);
		set_ctl(3'h6);
		wait_idle();
		check_heard();
		test_done("disable");
		f.fifoEnable = 1'b0;
		configure(f, div);
		remote_serial_device_inst.send(8'h3C, 12'h000, 0);
		remote_serial_device_inst.send(8'h5A, 12'h000, 0);
		check({10'h000, status.overrun, status.rxLevelHit}, 12'h003);
		repeat (40 * bitClks) @(negedge clk);
		check({11'h000, status.rxTimeout}, 12'h001);
		recv_check(exp_word(8'h3C, 1'b0, 1'b0), 12'hFFF);
		repeat (2) @(negedge clk);
		check({10'h000, status.rxEmpty, status.rxTimeout}, 12'h002);
		pulse(errorClear);
		pulse(timeoutClear);
		check({11'h000, status.overrun}, 12'h000);
		test_done("overrun");
		f.fifoEnable = 1'b1;
		configure(f, div);
		set_ctl(3'h5);
		txLevelIn = 3'h4;
		pulse(levelWrite);
		for (int i = 0; i < 17; i++) push(8'($random(seed)));
		void'(sent.pop_back());
		check({9'h000, status.txFull, status.busy, status.txLevelHit}, 12'h006);
		set_ctl(3'h7);
		wait_idle();
		check({11'h000, status.txLevelHit}, 12'h001);
		check_heard();
		test_done("fifo");
		final_report();
	end

	initial begin
		repeat (90000) @(posedge clk);
		n_errors++;
		final_report();
	end
endmodule
